// File: rtl/pmt_pkg.sv
// Package of constants for the period match timer.
// Assumes a single 40 MHz clock and an APB register bus with 32-bit data.
//
// Notes on behaviour
// (RQ1) Keep 8-bit count and period registers and compare them continuously.
// (RQ2) Timer clock is the instruction clock, oscillator divided by four.
// (RQ3) Prescale ratios 1:1, 1:4, 1:16; each prescaler pulse adds one.
// (RQ4) Count climbs upward from 00h until it equals the period.
// (RQ5) On a match the next increment loads 00h instead of adding one.
// (RQ6) Each match advances the postscaler, ratios 1:1 through 1:16.
// (RQ7) Postscaler output sets the match interrupt flag.
// (RQ8) Software may read and write count and period at any time.
// (RQ9) Reset sets count to 00h and period to FFh.
// (RQ10) Timer runs while the timer-on bit is 1, stops while 0.
// (RQ11) Count write, control write or reset clear prescaler and postscaler.
// (RQ12) A control write leaves the count value unchanged.
// (RQ13) Postscale select gives ratio one plus its value.
// (RQ14) Postscale select all ones gives ratio 1:16.
// (RQ15) Prescale select 00 divides by 1, 01 by 4, 1x by 16.
// (RQ16) Control: bit 7 reads zero, 6:3 postscale, 2 on, 1:0 prescale.

package pmt_pkg;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_COUNT  = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_CLEAR  = 8'h10;
  localparam logic [7:0] ADDR_ENABLE = 8'h14;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int unsigned CTRL_PSC_LSB  = 0;
  localparam int unsigned CTRL_ON_BIT   = 2;
  localparam int unsigned CTRL_POST_LSB = 3;
  localparam logic [7:0]  CTRL_MASK     = 8'h7F;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  COUNT_RST     = 8'h00;
  localparam logic [7:0]  PERIOD_RST    = 8'hFF;
  localparam int unsigned STAT_MATCH    = 0;

  // ****************************************
  // Prescaler terminal counts per select code
  // ****************************************
  localparam logic [3:0] PSC_LIM_1  = 4'h0;
  localparam logic [3:0] PSC_LIM_4  = 4'h3;
  localparam logic [3:0] PSC_LIM_16 = 4'hF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned INSTR_DIV     = 4;

endpackage : pmt_pkg

// File: rtl/pmt_div_if.sv
// Interface joining the timer core to one of its divide counters.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface pmt_div_if #(parameter int W = 4);
  logic         tick;   // Count enable pulse.
  logic         clr;    // Synchronous clear of the counter.
  logic [W-1:0] limit;  // Terminal value, ratio is limit plus one.
  logic         pulse;  // Output pulse on the wrapping tick.
  logic [W-1:0] cnt;    // Current count, for observation.

  modport ctl (output tick, clr, limit, input pulse, cnt);
  modport div (input tick, clr, limit, output pulse, cnt);
endinterface : pmt_div_if

`default_nettype wire

// File: rtl/pmt_divider.sv
// Programmable divide counter used as prescaler and postscaler.
// Assumes tick and clr come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module pmt_divider
  import pmt_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic clk,   // System clock.
  input wire logic rst,   // Synchronous reset, active high.
  pmt_div_if.div   dv     // Control and pulse link.
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         wrap;

  // Wrap also when the limit was lowered below the count.
  assign wrap     = (cnt_q >= dv.limit);
  assign cnt_d    = wrap ? '0 : cnt_q + W'(1);
  assign dv.pulse = dv.tick & wrap & ~dv.clr;
  assign dv.cnt   = cnt_q;

  // Counter clears on reset or request, else advances on tick.
  always_ff @(posedge clk) begin
    if (rst || dv.clr) begin
      cnt_q <= '0;
    end else if (dv.tick) begin
      cnt_q <= cnt_d;
    end
  end

endmodule : pmt_divider

`default_nettype wire

// File: rtl/pmt_timer.sv
// Top of the 8-bit period match timer with its APB register file.
// Assumes an APB master on CLK; IRQ goes to an interrupt controller.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module pmt_timer
  import pmt_pkg::*;
(
  input  wire logic        CLK,      // System clock, 40 MHz.
  input  wire logic        RST,      // Synchronous reset, active high.
  input  wire logic        PSEL,     // APB select.
  input  wire logic        PENABLE,  // APB access phase.
  input  wire logic        PWRITE,   // APB direction, high for write.
  input  wire logic [7:0]  PADDR,    // APB byte address.
  input  wire logic [31:0] PWDATA,   // APB write data.
  output var  logic [31:0] PRDATA,   // APB read data.
  output var  logic        PREADY,   // APB transfer done.
  output var  logic        PSLVERR,  // APB error, unmapped address.
  output var  logic        IRQ       // Level interrupt.
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [1:0]  instr_q;
  logic        instr_tick;
  logic [7:0]  ctrl_q;
  logic [7:0]  count_q;
  logic [7:0]  count_d;
  logic [7:0]  period_q;
  logic        status_q;
  logic        status_d;
  logic        enable_q;
  logic        pready_q;
  logic        perr_q;
  logic [31:0] prdata_q;
  logic        irq_q;
  logic        ctrl_on;
  logic [1:0]  psc_sel;
  logic [3:0]  post_sel;
  logic [3:0]  psc_lim;
  logic        match;
  logic        inc;
  logic        acc;
  logic        wr_en;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_period;
  logic        wr_clear;
  logic        wr_enable;
  logic        hit;
  logic [31:0] rdata_w;
  logic        scl_clr;

  pmt_div_if #(.W(4)) psc_if ();
  pmt_div_if #(.W(4)) post_if ();

  // ****************************************
  // Instruction clock
  // ****************************************

  // Free divide by four gives one instruction tick per four CLKs.
  assign instr_tick = (instr_q == 2'(INSTR_DIV - 1)); // [RQ2]

  always_ff @(posedge CLK) begin
    if (RST) begin
      instr_q <= 2'h0;
    end else begin
      instr_q <= instr_q + 2'h1;
    end
  end

  // ****************************************
  // APB decode
  // ****************************************

  // The access phase waits one cycle, so each transfer is three edges.
  assign acc       = PSEL & PENABLE;
  assign wr_en     = acc & PWRITE & pready_q;
  assign wr_ctrl   = wr_en & (PADDR == ADDR_CTRL);
  assign wr_count  = wr_en & (PADDR == ADDR_COUNT);
  assign wr_period = wr_en & (PADDR == ADDR_PERIOD);
  assign wr_clear  = wr_en & (PADDR == ADDR_CLEAR);
  assign wr_enable = wr_en & (PADDR == ADDR_ENABLE);
  assign hit       = (PADDR == ADDR_CTRL)   | (PADDR == ADDR_COUNT)
                   | (PADDR == ADDR_PERIOD) | (PADDR == ADDR_STATUS)
                   | (PADDR == ADDR_CLEAR)  | (PADDR == ADDR_ENABLE);

  // Read mux; count and period read live at any time.
  assign rdata_w =
      (PADDR == ADDR_CTRL)   ? {24'h00_0000, ctrl_q}        :
      (PADDR == ADDR_COUNT)  ? {24'h00_0000, count_q}       : // [RQ8]
      (PADDR == ADDR_PERIOD) ? {24'h00_0000, period_q}      : // [RQ8]
      (PADDR == ADDR_STATUS) ? {31'h0000_0000, status_q}    :
      (PADDR == ADDR_ENABLE) ? {31'h0000_0000, enable_q}    :
                               32'h0000_0000;

  // Ready, read data and error are all registered.
  always_ff @(posedge CLK) begin
    if (RST) begin
      pready_q <= 1'b0;
      perr_q   <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc & ~pready_q;
      perr_q   <= acc & ~pready_q & ~hit;
      if (acc && !pready_q && !PWRITE) begin
        prdata_q <= rdata_w;
      end
    end
  end

  // ****************************************
  // Control register
  // ****************************************

  // Bit 7 is never stored, so it always reads zero.
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= CTRL_RST; // [RQ16]
    end else if (wr_ctrl) begin
      ctrl_q <= PWDATA[7:0] & CTRL_MASK; // [RQ16]
    end
  end

  // Field split of the control register.
  assign ctrl_on  = ctrl_q[CTRL_ON_BIT];           // [RQ16]
  assign psc_sel  = ctrl_q[CTRL_PSC_LSB +: 2];      // [RQ16]
  assign post_sel = ctrl_q[CTRL_POST_LSB +: 4];     // [RQ16]

  // ****************************************
  // Prescaler
  // ****************************************

  // Select code to terminal count; upper bit set means 1:16.
  assign psc_lim = psc_sel[1]          ? PSC_LIM_16 : // [RQ15]
                   (psc_sel == 2'b01)  ? PSC_LIM_4  : // [RQ3]
                                         PSC_LIM_1;

  // Writes to count or control restart both scalers.
  assign scl_clr = wr_count | wr_ctrl; // [RQ11]

  // Instruction ticks reach the prescaler only while the timer runs.
  assign psc_if.tick  = instr_tick & ctrl_on; // [RQ10]
  assign psc_if.clr   = scl_clr;              // [RQ11]
  assign psc_if.limit = psc_lim;              // [RQ3]

  pmt_divider #(.W(4)) u_psc (
    .clk (CLK),
    .rst (RST),
    .dv  (psc_if)
  );

  // One prescaler pulse is one count increment.
  assign inc = psc_if.pulse; // [RQ3]

  // ****************************************
  // Count and period
  // ****************************************

  // Continuous equality compare of count and period.
  assign match = (count_q == period_q); // [RQ1]

  // Next count: software write wins, match reloads zero, else add one.
  assign count_d = wr_count     ? PWDATA[7:0] : // [RQ8]
                   (inc && match) ? 8'h00     : // [RQ5]
                   inc          ? count_q + 8'h01 : // [RQ4]
                                  count_q;    // [RQ12]

  always_ff @(posedge CLK) begin
    if (RST) begin
      count_q <= COUNT_RST; // [RQ9]
    end else begin
      count_q <= count_d;
    end
  end

  // Period is plain storage, writable at any time.
  always_ff @(posedge CLK) begin
    if (RST) begin
      period_q <= PERIOD_RST; // [RQ9]
    end else if (wr_period) begin
      period_q <= PWDATA[7:0]; // [RQ8]
    end
  end

  // ****************************************
  // Postscaler
  // ****************************************

  // Every wrap on match advances the postscaler by one.
  assign post_if.tick  = inc & match; // [RQ6]
  assign post_if.clr   = scl_clr;     // [RQ11]
  assign post_if.limit = post_sel;    // [RQ13] [RQ14]

  pmt_divider #(.W(4)) u_post (
    .clk (CLK),
    .rst (RST),
    .dv  (post_if)
  );

  // ****************************************
  // Interrupt
  // ****************************************

  // Sticky flag; a set in the clearing cycle wins over the clear.
  assign status_d = (status_q & ~(wr_clear & PWDATA[STAT_MATCH]))
                  | post_if.pulse; // [RQ7]

  always_ff @(posedge CLK) begin
    if (RST) begin
      status_q <= 1'b0;
      enable_q <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      if (wr_enable) begin
        enable_q <= PWDATA[STAT_MATCH];
      end
      irq_q <= status_q & enable_q;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Every output is a flip-flop.
  assign PRDATA  = prdata_q;
  assign PREADY  = pready_q;
  assign PSLVERR = perr_q;
  assign IRQ     = irq_q;

  // ****************************************
  // Checks
  // ****************************************

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Count returns to zero after a matching increment.
  chk_count_wrap: // [RQ5]
    assert property (inc && match |=> count_q == 8'h00)
    else $error("count did not wrap to zero on match");

  // Count adds exactly one on a non-matching increment.
  chk_count_step: // [RQ4]
    assert property (inc && !match |=>
                     count_q == $past(count_q) + 8'h01)
    else $error("count did not step by one");

  // A stopped timer holds its count unless software writes it.
  chk_stop_hold: // [RQ10]
    assert property (!ctrl_on && !wr_count |=> $stable(count_q))
    else $error("count moved while timer off");

  // A control write leaves the count alone.
  chk_ctrl_keeps: // [RQ12]
    assert property (wr_ctrl |=> $stable(count_q))
    else $error("control write changed the count");

  // Both scalers are zero after a count or control write.
  chk_scale_clear: // [RQ11]
    assert property (scl_clr |=> psc_if.cnt == 4'h0
                                 && post_if.cnt == 4'h0)
    else $error("scalers not cleared by write");

  // An increment only ever comes from the prescaler terminal count.
  chk_psc_ratio: // [RQ3]
    assert property (inc |-> psc_if.cnt == psc_lim && instr_tick && ctrl_on)
    else $error("increment without prescaler terminal count");

  // Postscaler output raises the flag and then the interrupt.
  chk_flag_irq: // [RQ7]
    assert property (post_if.pulse && enable_q && !wr_enable
                     |=> status_q ##1 IRQ)
    else $error("flag or interrupt missing after postscaler");

  // Count and period take their reset values.
  chk_reset_vals: // [RQ9]
    assert property ($fell(RST) |->
                     count_q == COUNT_RST && period_q == PERIOD_RST)
    else $error("wrong values after reset");

  // Period takes written data on the write edge.
  chk_period_wr: // [RQ8]
    assert property (wr_period |=> period_q == $past(PWDATA[7:0]))
    else $error("period write lost");

  // The unimplemented control bit stays zero.
  chk_ctrl_bit7: // [RQ16]
    assert property (ctrl_q[7] == 1'b0)
    else $error("control bit 7 set");

  // The instruction tick comes once in every four clocks.
  chk_instr_rate: // [RQ2]
    assert property (instr_tick |=>
                     !instr_tick [*3] ##1 instr_tick)
    else $error("instruction tick not one in four");

  // A stopped timer never produces an increment.
  chk_off_no_inc: // [RQ10]
    assert property (!ctrl_on |-> !inc)
    else $error("increment while timer off");

  // A count write loads the written byte.
  chk_count_wr: // [RQ8]
    assert property (wr_count |=> count_q == $past(PWDATA[7:0]))
    else $error("count write lost");

  // The prescaler never counts past its terminal value.
  chk_psc_bound: // [RQ3]
    assert property (psc_if.cnt <= psc_lim)
    else $error("prescaler beyond terminal count");

  // The postscaler fires only after select plus one matches.
  chk_post_ratio: // [RQ13] [RQ14]
    assert property (post_if.pulse |-> post_if.cnt == post_sel)
    else $error("postscaler fired at wrong count");

  // The postscaler moves only on a match or a clear.
  chk_post_hold: // [RQ6]
    assert property (!post_if.tick && !scl_clr |=> $stable(post_if.cnt))
    else $error("postscaler moved without a match");

  // The flag stays set until software clears it.
  chk_flag_sticky: // [RQ7]
    assert property (status_q && !(wr_clear && PWDATA[STAT_MATCH])
                     |=> status_q)
    else $error("match flag dropped without a clear");

  // The interrupt follows the enabled flag one clock later.
  chk_irq_level: // [RQ7]
    assert property (IRQ == $past(status_q && enable_q))
    else $error("interrupt does not follow enabled flag");

  // The period holds unless software writes it.
  chk_period_hold: // [RQ8]
    assert property (!wr_period |=> $stable(period_q))
    else $error("period changed without a write");

  // A control write stores the byte with bit 7 masked off.
  chk_ctrl_wr: // [RQ16]
    assert property (wr_ctrl |=>
                     ctrl_q == ($past(PWDATA[7:0]) & CTRL_MASK))
    else $error("control write lost");

endmodule : pmt_timer

`default_nettype wire

// File: verification/pmt_timer_test.sv
// Self-checking bench for the period match timer over APB.
// Assumes pmt_timer and pmt_pkg; the bench alone drives every input.
`timescale 1ns/100ps
`default_nettype none

module pmt_timer_test
  import pmt_pkg::*;
;
  typedef struct packed {
    logic        rd;   // Read data is compared.
    logic        le;   // Expected read data is an upper bound.
    logic [31:0] dat;  // Expected read data.
    logic        err;  // Expected error response.
  } pmt_note_s;

  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  pmt_note_s   notes[$];
  pmt_note_s   note;
  int          n_mismatch;
  int          cmp_count;
  logic [7:0]  per;
  logic [3:0]  post_tab[4];

  pmt_timer dut_u (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq)
  );

  // ****************************************
  // Tasks
  // ****************************************

  // Counts a comparison and reports a mismatch; unknowns never pass.
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got, input logic le);
    cmp_count++;
    if (le ? ((got > exp) !== 1'b0) : (got !== exp)) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One APB transfer; the request is held until PREADY is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input pmt_note_s n);
    notes.push_back(n);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic e = 1'b0);
    apb(1'b1, a, d, '{1'b0, 1'b0, 32'h0000_0000, e});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic le = 1'b0, input logic e = 1'b0);
    apb(1'b0, a, 32'h0000_0000, '{1'b1, le, x, e});
  endtask : rd

  // Runs to the postscaler output and checks when the interrupt rises.
  task automatic run_irq(input logic [1:0] ps, input logic [3:0] post,
                         input logic [7:0] p);
    int unsigned d;
    int unsigned k;
    d = 4 * (ps == 2'b00 ? 1 : (ps == 2'b01 ? 4 : 16)) * (p + 1) * (post + 1);
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_CLEAR, 32'h0000_0001);
    wr(ADDR_PERIOD, {24'h0000_00, p});
    wr(ADDR_COUNT, 32'h0000_0000);
    wr(ADDR_ENABLE, 32'h0000_0001);
    wr(ADDR_CTRL, {25'h000_0000, post, 1'b1, ps});
    // The free instruction phase leaves four clocks of slack.
    repeat (d - 2) @(posedge clk);
    check("irq early", 32'h0, {31'h0, irq}, 1'b0);
    k = 0;
    while (irq !== 1'b1 && k < 4) begin
      @(posedge clk);
      k++;
    end
    check("irq late", 32'h1, {31'h0, irq}, 1'b0);
    wr(ADDR_ENABLE, 32'h0000_0000);
    repeat (3) @(posedge clk);
    check("irq masked", 32'h0, {31'h0, irq}, 1'b0);
    rd(ADDR_STATUS, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_CLEAR, 32'h0000_0001);
    rd(ADDR_STATUS, 32'h0000_0000);
  endtask : run_irq

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // ****************************************
  // Processes
  // ****************************************

  // Free running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Takes the oldest note whenever a transfer completes and compares.
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0) begin
        check("spare ready", 32'h0, 32'h1, 1'b0);
      end else begin
        note = notes.pop_front();
        if (note.rd) begin
          check("read data", note.dat, prdata, note.le);
        end
        check("slave error", {31'h0, note.err}, {31'h0, pslverr}, 1'b0);
      end
    end
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    test_done();
  end

  // Main sequence.
  initial begin
    rst        = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0000_0000;
    n_mismatch = 0;
    cmp_count  = 0;
    void'($urandom(43794));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, 32'h0000_0000);
    rd(ADDR_COUNT, 32'h0000_0000);
    rd(ADDR_PERIOD, 32'h0000_00FF);
    rd(ADDR_STATUS, 32'h0000_0000);
    rd(ADDR_ENABLE, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000, 1'b0, 1'b1);
    wr(8'h18, 32'h0000_0011, 1'b1);
    per = 8'($urandom_range(255, 0));
    wr(ADDR_PERIOD, {24'h0000_00, per});
    rd(ADDR_PERIOD, {24'h0000_00, per});
    wr(ADDR_COUNT, 32'h0000_005A);
    repeat (100) @(posedge clk);
    rd(ADDR_COUNT, 32'h0000_005A);
    wr(ADDR_CTRL, 32'h0000_00FB);
    rd(ADDR_CTRL, 32'h0000_007B);
    rd(ADDR_COUNT, 32'h0000_005A);
    per = 8'($urandom_range(6, 1));
    wr(ADDR_PERIOD, {24'h0000_00, per});
    wr(ADDR_COUNT, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0004);
    repeat (20) rd(ADDR_COUNT, {24'h0000_00, per}, 1'b1);
    // A reset in mid-run, with the timer going, restores period, count, control and status.
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_PERIOD, 32'h0000_00FF);
    rd(ADDR_COUNT, 32'h0000_0000);
    rd(ADDR_CTRL, 32'h0000_0000);
    rd(ADDR_STATUS, 32'h0000_0000);
    post_tab = '{4'h0, 4'h7, 4'hF, 4'($urandom_range(14, 1))};
    for (int i = 0; i < 4; i++) begin
      per = 8'($urandom_range(3, 1));
      run_irq(2'(i), post_tab[i], per);
    end
    repeat (4) @(posedge clk);
    test_done();
  end

endmodule : pmt_timer_test

`default_nettype wire
